// [rtl/asci_pkg.sv]
// package for the asynchronous serial interface: register map, fields, states
// assumes a 32-bit axi4-lite register bus and one 100 MHz clock
package asci_pkg;

  // register byte offsets; the baud offset is the one printed, the rest sit beside it
  localparam logic [15:0] ASCI_OFS_BAUD = 16'h102B;
  localparam logic [15:0] ASCI_ADDR_BAUD = 16'h40AC; // index 0x102B times four
  localparam logic [15:0] ASCI_ADDR_CTL1 = 16'h40B0;
  localparam logic [15:0] ASCI_ADDR_CTL2 = 16'h40B4;
  localparam logic [15:0] ASCI_ADDR_STAT = 16'h40B8;
  localparam logic [15:0] ASCI_ADDR_DATA = 16'h40BC;
  localparam logic [15:0] ASCI_ADDR_MASK = 16'h40C0;

  // baud register fields
  localparam int ASCI_BAUD_CLR_BIT = 7;
  localparam int ASCI_BAUD_SCP_LSB = 4;
  localparam int ASCI_BAUD_SCR_LSB = 0;
  localparam logic [7:0] ASCI_BAUD_RST = 8'h00;
  localparam logic [7:0] ASCI_BAUD_WMASK = 8'hB7;
  // control one: bit 4 word length, bit 0 ninth transmit bit
  localparam int ASCI_CTL1_NINE_BIT = 4;
  localparam int ASCI_CTL1_T8_BIT = 0;
  // control two: bit 3 transmit enable, bit 2 receive enable, bit 0 send break
  localparam int ASCI_CTL2_TE_BIT = 3;
  localparam int ASCI_CTL2_RE_BIT = 2;
  localparam int ASCI_CTL2_BRK_BIT = 0;
  // status: 7 tx buffer empty, 6 tx complete, 5 rx full, 3 overrun, 2 noise, 1 frame
  localparam int ASCI_ST_TDRE = 7;
  localparam int ASCI_ST_TC = 6;
  localparam int ASCI_ST_RDRF = 5;
  localparam int ASCI_ST_OVR = 3;
  localparam int ASCI_ST_NF = 2;
  localparam int ASCI_ST_FE = 1;
  localparam logic [7:0] ASCI_CTL_RST = 8'h00;

  // oversampling and prescaler divisions
  localparam int ASCI_OVS = 16;
  localparam logic [3:0] ASCI_DIV_P0 = 4'd1;
  localparam logic [3:0] ASCI_DIV_P1 = 4'd3;
  localparam logic [3:0] ASCI_DIV_P2 = 4'd4;
  localparam logic [3:0] ASCI_DIV_P3 = 4'd13;

  // axi responses
  localparam logic [1:0] ASCI_RESP_OK = 2'b00;
  localparam logic [1:0] ASCI_RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {ASCI_TX_IDLE = 2'b00, ASCI_TX_START = 2'b01,
                            ASCI_TX_DATA = 2'b11, ASCI_TX_STOP = 2'b10} asci_tx_t;
  typedef enum logic [1:0] {ASCI_RX_IDLE = 2'b00, ASCI_RX_START = 2'b01,
                            ASCI_RX_DATA = 2'b11, ASCI_RX_STOP = 2'b10} asci_rx_t;

  // receive error bundle carried with a character
  typedef struct packed {
    logic ovr;
    logic nf;
    logic fe;
  } asci_err_t;

  // divide select of the prescaler
  function automatic logic [3:0] asci_pre_div(input logic [1:0] sel);
    unique case (sel)
      2'b00: asci_pre_div = ASCI_DIV_P0;
      2'b01: asci_pre_div = ASCI_DIV_P1;
      2'b10: asci_pre_div = ASCI_DIV_P2;
      default: asci_pre_div = ASCI_DIV_P3;
    endcase
  endfunction

  // majority of three samples
  function automatic logic asci_vote(input logic [2:0] s);
    asci_vote = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

endpackage

// [rtl/asci_top.sv]
// asynchronous serial interface: nrz framer with double-buffered transmit
// assumes an axi4-lite master on CLK; RXD comes from an outside node
module asci_top
  import asci_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic [15:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [15:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic RXD,
  output logic TXD,
  output logic IRQ
);

  // register state
  logic [7:0] baud_q, baud_d;       // baud_rate_select
  logic [7:0] ctl1_q, ctl1_d;       // serial_control_one
  logic [7:0] ctl2_q, ctl2_d;       // serial_control_two
  logic [7:0] mask_q, mask_d;       // interrupt mask, status layout
  logic [7:0] rxbuf_q, rxbuf_d;     // serial_data_buffer, read side
  logic rx9_q, rx9_d;               // received ninth bit
  logic [8:0] txbuf_q, txbuf_d;     // serial_data_buffer, write side
  logic tdre_q, tdre_d, tc_q, tc_d, rdrf_q, rdrf_d;
  asci_err_t err_q, err_d;
  logic armed_q, armed_d;           // status read seen, waiting for the data read
  // axi channel state
  logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d, arr_q, arr_d;
  logic [15:0] awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic irq_q, irq_d;

  // rx pin synchroniser; stage one feeds stage two only
  logic rx_m_q, rx_s_q;
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      rx_m_q <= 1'b1;
      rx_s_q <= 1'b1;
    end
    else
    begin
      rx_m_q <= RXD;
      rx_s_q <= rx_m_q;
    end
  end

  // baud generator: prescaler then binary rate stage, 16x tick
  logic [3:0] pre_q, pre_d;
  logic [6:0] rate_q, rate_d;
  logic tick_q, tick_d;
  logic [3:0] pre_lim;
  logic [6:0] rate_lim;
  always_comb
  begin
    pre_lim = asci_pre_div(baud_q[ASCI_BAUD_SCP_LSB +: 2]) - 4'd1;
    rate_lim = 7'((7'd1 << baud_q[ASCI_BAUD_SCR_LSB +: 3]) - 7'd1);
    pre_d = pre_q;
    rate_d = rate_q;
    tick_d = 1'b0;
    if (baud_q[ASCI_BAUD_CLR_BIT])
    begin
      // test clear holds both counters at zero
      pre_d = '0;
      rate_d = '0;
    end
    else if (pre_q >= pre_lim)
    begin
      // >= so a prescaler change takes effect at once
      pre_d = '0;
      if (rate_q >= rate_lim)
      begin
        rate_d = '0;
        tick_d = 1'b1;
      end
      else
        rate_d = rate_q + 7'd1;
    end
    else
      pre_d = pre_q + 4'd1;
  end
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      pre_q <= '0;
      rate_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      pre_q <= pre_d;
      rate_q <= rate_d;
      tick_q <= tick_d;
    end
  end

  // transmitter; one tick stream shared with the receiver
  asci_tx_t txs_q, txs_d;
  logic [3:0] txo_q, txo_d;   // oversample phase
  logic [3:0] txn_q, txn_d;   // bit index
  logic [8:0] txsh_q, txsh_d;
  logic txd_q, txd_d;
  logic tx_load;              // shifter takes the buffer
  logic nine;
  always_comb
  begin
    nine = ctl1_q[ASCI_CTL1_NINE_BIT];
    txs_d = txs_q;
    txo_d = txo_q;
    txn_d = txn_q;
    txsh_d = txsh_q;
    tx_load = 1'b0;
    if (tick_q)
    begin
      txo_d = txo_q + 4'd1;
      unique case (txs_q)
        ASCI_TX_IDLE:
        begin
          txo_d = '0;
          if (ctl2_q[ASCI_CTL2_TE_BIT] && (!tdre_q || ctl2_q[ASCI_CTL2_BRK_BIT]))
          begin
            // shifter is filled from the data buffer, or with zeros for a break frame when the buffer is empty
            tx_load = !tdre_q;
            txsh_d = tdre_q ? 9'h000 : txbuf_q;
            txs_d = ASCI_TX_START;
          end
        end
        ASCI_TX_START:
          if (txo_q == 4'hF)
          begin
            txn_d = '0;
            txs_d = ASCI_TX_DATA;
          end
        ASCI_TX_DATA:
          if (txo_q == 4'hF)
          begin
            txsh_d = {1'b0, txsh_q[8:1]};
            txn_d = txn_q + 4'd1;
            if (txn_q == (nine ? 4'd8 : 4'd7))
              txs_d = ASCI_TX_STOP;
          end
        default:
          if (txo_q == 4'hF)
            txs_d = ASCI_TX_IDLE;
      endcase
    end
    // pin: start zero, data, stop one; break forces zero for whole frames
    unique case (txs_q)
      ASCI_TX_START: txd_d = 1'b0;
      ASCI_TX_DATA: txd_d = txsh_q[0] & !ctl2_q[ASCI_CTL2_BRK_BIT];
      ASCI_TX_STOP: txd_d = !ctl2_q[ASCI_CTL2_BRK_BIT];
      // the one idle tick between break frames stays low, so the line never blips
      default: txd_d = !(ctl2_q[ASCI_CTL2_TE_BIT] && ctl2_q[ASCI_CTL2_BRK_BIT]);
    endcase
  end
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      txs_q <= ASCI_TX_IDLE;
      txo_q <= '0;
      txn_q <= '0;
      txsh_q <= '0;
      txd_q <= 1'b1;
    end
    else
    begin
      txs_q <= txs_d;
      txo_q <= txo_d;
      txn_q <= txn_d;
      txsh_q <= txsh_d;
      txd_q <= txd_d;
    end
  end

  // receiver with samples 7, 8, 9 of sixteen
  asci_rx_t rxs_q, rxs_d;
  logic [3:0] rxo_q, rxo_d, rxn_q, rxn_d;
  logic [2:0] smp_q, smp_d;
  logic [8:0] rxsh_q, rxsh_d;
  logic noisy_q, noisy_d;
  logic rx_done;              // character complete this cycle
  logic rx_fe;
  logic bitv;
  always_comb
  begin
    rxs_d = rxs_q;
    rxo_d = rxo_q;
    rxn_d = rxn_q;
    smp_d = smp_q;
    rxsh_d = rxsh_q;
    noisy_d = noisy_q;
    rx_done = 1'b0;
    rx_fe = 1'b0;
    bitv = asci_vote(smp_q);
    if (tick_q && ctl2_q[ASCI_CTL2_RE_BIT])
    begin
      rxo_d = rxo_q + 4'd1;
      if (rxo_q >= 4'd7 && rxo_q <= 4'd9)
        smp_d = {smp_q[1:0], rx_s_q};
      unique case (rxs_q)
        ASCI_RX_IDLE:
        begin
          rxo_d = '0;
          noisy_d = 1'b0;
          if (!rx_s_q)
            rxs_d = ASCI_RX_START;
        end
        ASCI_RX_START:
          if (rxo_q == 4'hF)
          begin
            // a high start bit is a glitch; back to idle
            rxs_d = bitv ? ASCI_RX_IDLE : ASCI_RX_DATA;
            noisy_d = (smp_q != 3'b000) && (smp_q != 3'b111);
            rxn_d = '0;
          end
        ASCI_RX_DATA:
          if (rxo_q == 4'hF)
          begin
            // fill from the top so the first bit ends lowest
            rxsh_d = nine ? {bitv, rxsh_q[8:1]} : {1'b0, bitv, rxsh_q[7:1]};
            noisy_d = noisy_q | ((smp_q != 3'b000) && (smp_q != 3'b111));
            rxn_d = rxn_q + 4'd1;
            if (rxn_q == (nine ? 4'd8 : 4'd7))
              rxs_d = ASCI_RX_STOP;
          end
        default:
          if (rxo_q == 4'hF)
          begin
            rx_done = 1'b1;
            rx_fe = !bitv;
            noisy_d = noisy_q | ((smp_q != 3'b000) && (smp_q != 3'b111));
            rxs_d = ASCI_RX_IDLE;
          end
      endcase
    end
  end
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      rxs_q <= ASCI_RX_IDLE;
      rxo_q <= '0;
      rxn_q <= '0;
      smp_q <= 3'b111;
      rxsh_q <= '0;
      noisy_q <= 1'b0;
    end
    else
    begin
      rxs_q <= rxs_d;
      rxo_q <= rxo_d;
      rxn_q <= rxn_d;
      smp_q <= smp_d;
      rxsh_q <= rxsh_d;
      noisy_q <= noisy_d;
    end
  end

  // axi4-lite slave and register file
  logic wr_go, rd_go, wr_hit, rd_hit;
  logic [7:0] stat;
  logic rd_stat, rd_data;
  always_comb
  begin
    aw_d = aw_q;
    w_d = w_q;
    awa_d = awa_q;
    wd_d = wd_q;
    bv_d = bv_q;
    bresp_d = bresp_q;
    rv_d = rv_q;
    rd_d = rd_q;
    rresp_d = rresp_q;
    arr_d = 1'b0;
    baud_d = baud_q;
    ctl1_d = ctl1_q;
    ctl2_d = ctl2_q;
    mask_d = mask_q;
    txbuf_d = txbuf_q;
    tdre_d = tdre_q;
    tc_d = tc_q;
    rdrf_d = rdrf_q;
    err_d = err_q;
    rxbuf_d = rxbuf_q;
    rx9_d = rx9_q;
    armed_d = armed_q;
    rd_stat = 1'b0;
    rd_data = 1'b0;
    stat = {tdre_q, tc_q, rdrf_q, 1'b0, err_q.ovr, err_q.nf, err_q.fe, 1'b0};
    // take address and data in either order
    if (S_AXI_AWVALID && !aw_q)
    begin
      aw_d = 1'b1;
      awa_d = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !w_q)
    begin
      w_d = 1'b1;
      wd_d = S_AXI_WDATA;
    end
    wr_go = aw_q && w_q && !bv_q;
    wr_hit = 1'b0;
    if (wr_go)
    begin
      aw_d = 1'b0;
      w_d = 1'b0;
      bv_d = 1'b1;
      wr_hit = 1'b1;
      unique case (awa_q)
        ASCI_ADDR_BAUD: baud_d = wd_q[7:0] & ASCI_BAUD_WMASK;
        ASCI_ADDR_CTL1: ctl1_d = wd_q[7:0];
        ASCI_ADDR_CTL2: ctl2_d = wd_q[7:0];
        ASCI_ADDR_MASK: mask_d = wd_q[7:0];
        ASCI_ADDR_DATA:
        begin
          txbuf_d = {ctl1_q[ASCI_CTL1_T8_BIT], wd_q[7:0]};
          tdre_d = 1'b0;
          tc_d = 1'b0;
        end
        ASCI_ADDR_STAT: wr_hit = 1'b1;
        default: wr_hit = 1'b0;
      endcase
      bresp_d = wr_hit ? ASCI_RESP_OK : ASCI_RESP_SLVERR;
    end
    if (bv_q && S_AXI_BREADY)
      bv_d = 1'b0;
    rd_go = S_AXI_ARVALID && !rv_q && !arr_q;
    rd_hit = 1'b0;
    if (rd_go)
    begin
      arr_d = 1'b1;
      rv_d = 1'b1;
      rd_hit = 1'b1;
      rd_d = '0;
      unique case (S_AXI_ARADDR)
        ASCI_ADDR_BAUD: rd_d[7:0] = baud_q;
        ASCI_ADDR_CTL1: rd_d[7:0] = {ctl1_q[7:1], rx9_q};
        ASCI_ADDR_CTL2: rd_d[7:0] = ctl2_q;
        ASCI_ADDR_MASK: rd_d[7:0] = mask_q;
        ASCI_ADDR_STAT:
        begin
          rd_d[7:0] = stat;
          rd_stat = 1'b1;
        end
        ASCI_ADDR_DATA:
        begin
          rd_d[7:0] = rxbuf_q;
          rd_data = 1'b1;
        end
        default: rd_hit = 1'b0;
      endcase
      rresp_d = rd_hit ? ASCI_RESP_OK : ASCI_RESP_SLVERR;
    end
    if (rv_q && S_AXI_RREADY)
      rv_d = 1'b0;
    // status then data read clears rx flags
    if (rd_stat)
      armed_d = 1'b1;
    if (rd_data && armed_q)
    begin
      err_d = '0;
      rdrf_d = 1'b0;
      armed_d = 1'b0;
    end
    // transmit handoff; the set of tdre follows the load
    if (tx_load)
      tdre_d = 1'b1;
    if (tick_q && txs_q == ASCI_TX_STOP && txo_q == 4'hF && tdre_q)
      tc_d = 1'b1;
    // receive completion wins over a clearing read in the same cycle
    if (rx_done)
    begin
      if (rdrf_d)
        err_d.ovr = 1'b1;
      else
      begin
        rxbuf_d = rxsh_q[7:0];
        rx9_d = rxsh_q[8];
        rdrf_d = 1'b1;
        err_d.nf = noisy_d;
        err_d.fe = rx_fe;
      end
    end
    irq_d = |(stat & mask_q);
  end
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= '0;
      wd_q <= '0;
      bv_q <= 1'b0;
      bresp_q <= ASCI_RESP_OK;
      rv_q <= 1'b0;
      rd_q <= '0;
      rresp_q <= ASCI_RESP_OK;
      arr_q <= 1'b0;
      baud_q <= ASCI_BAUD_RST; // fastest prescale
      ctl1_q <= ASCI_CTL_RST;
      ctl2_q <= ASCI_CTL_RST;
      mask_q <= ASCI_CTL_RST;
      txbuf_q <= '0;
      tdre_q <= 1'b1;
      tc_q <= 1'b1;
      rdrf_q <= 1'b0;
      err_q <= '0;
      rxbuf_q <= '0;
      rx9_q <= 1'b0;
      armed_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      aw_q <= aw_d;
      w_q <= w_d;
      awa_q <= awa_d;
      wd_q <= wd_d;
      bv_q <= bv_d;
      bresp_q <= bresp_d;
      rv_q <= rv_d;
      rd_q <= rd_d;
      rresp_q <= rresp_d;
      arr_q <= arr_d;
      baud_q <= baud_d;
      ctl1_q <= ctl1_d;
      ctl2_q <= ctl2_d;
      mask_q <= mask_d;
      txbuf_q <= txbuf_d;
      tdre_q <= tdre_d;
      tc_q <= tc_d;
      rdrf_q <= rdrf_d;
      err_q <= err_d;
      rxbuf_q <= rxbuf_d;
      rx9_q <= rx9_d;
      armed_q <= armed_d;
      irq_q <= irq_d;
    end
  end

  // outputs straight from flops
  assign S_AXI_AWREADY = !aw_q;
  assign S_AXI_WREADY = !w_q;
  assign S_AXI_BVALID = bv_q;
  assign S_AXI_BRESP = bresp_q;
  assign S_AXI_ARREADY = arr_q;
  assign S_AXI_RVALID = rv_q;
  assign S_AXI_RDATA = rd_q;
  assign S_AXI_RRESP = rresp_q;
  assign TXD = txd_q;
  assign IRQ = irq_q;

  // checks
  a_idle_high: assert property (@(posedge CLK) disable iff (RST)
    (txs_q == ASCI_TX_IDLE && $past(txs_q) == ASCI_TX_IDLE &&
    !$past(ctl2_q[ASCI_CTL2_BRK_BIT])) |-> TXD)
    else $error("line not high while idle");
  a_start_low: assert property (@(posedge CLK) disable iff (RST)
    (txs_q == ASCI_TX_START) |=> !TXD)
    else $error("start bit not low");
  a_stop_high: assert property (@(posedge CLK) disable iff (RST)
    (txs_q == ASCI_TX_STOP && !ctl2_q[ASCI_CTL2_BRK_BIT]) |=> TXD)
    else $error("stop bit not high");
  a_load_buf: assert property (@(posedge CLK) disable iff (RST)
    tx_load |=> (txsh_q == $past(txbuf_q)) && tdre_q)
    else $error("shifter not loaded from buffer");
  a_ovr_keep: assert property (@(posedge CLK) disable iff (RST)
    (rx_done && rdrf_q && !armed_q) |=> err_q.ovr && $stable(rxbuf_q))
    else $error("overrun lost old character");
  a_fe_set: assert property (@(posedge CLK) disable iff (RST)
    (rx_done && !rdrf_q && !bitv) |=> err_q.fe)
    else $error("framing error missed");
  a_clr_tick: assert property (@(posedge CLK) disable iff (RST)
    baud_q[ASCI_BAUD_CLR_BIT] |=> !tick_q && pre_q == 4'h0)
    else $error("test clear did not hold counters");
  a_pre_range: assert property (@(posedge CLK) disable iff (RST)
    $changed(pre_q) |-> pre_q <= 4'd12)
    else $error("prescaler beyond thirteen");
  a_nine_len: assert property (@(posedge CLK) disable iff (RST)
    (txs_q == ASCI_TX_DATA && !nine) |-> txn_q <= 4'd7)
    else $error("eight-bit frame overran");
  c_tx_frame: cover property (@(posedge CLK) txs_q == ASCI_TX_STOP);
  c_rx_char: cover property (@(posedge CLK) rx_done);
  c_overrun: cover property (@(posedge CLK) rx_done && rdrf_q);
  c_irq: cover property (@(posedge CLK) IRQ);

endmodule

// [tb/asci_node.sv]
// remote serial node: sends frames on the block's RXD, decodes frames from TXD
// assumes the bench sets bit_cyc and nbits to the block's bit time and word length
module asci_node (
  input wire logic clk,
  input wire logic tx_line,
  output logic rx_line
);
  timeunit 1ns;
  timeprecision 1ns;
  int bit_cyc = 16; // clocks per bit
  int nbits = 8; // data bits per character
  logic [8:0] got_q[$]; // decoded characters
  logic stop_q[$]; // stop level seen with each
  initial rx_line = 1'b1;

  // one frame out; glitch flips one centre sample of bit 0 only
  task automatic send(input logic [8:0] v, input logic stop, input logic glitch);
    rx_line <= 1'b0;
    repeat (bit_cyc) @(posedge clk);
    for (int i = 0; i < nbits; i++)
    begin
      for (int c = 0; c < bit_cyc; c++)
      begin
        rx_line <= (glitch && i == 0 && c == 8) ? ~v[i] : v[i];
        @(posedge clk);
      end
    end
    rx_line <= stop;
    repeat (bit_cyc) @(posedge clk);
    rx_line <= 1'b1;
    repeat (bit_cyc) @(posedge clk);
  endtask

  // receiver: centre sampling, so a short glitch cannot fool it
  initial
  begin
    logic [8:0] v;
    forever
    begin
      @(negedge tx_line);
      repeat (bit_cyc / 2) @(posedge clk);
      if (tx_line === 1'b0)
      begin
        v = '0;
        for (int i = 0; i < nbits; i++)
        begin
          repeat (bit_cyc) @(posedge clk);
          v[i] = tx_line;
        end
        repeat (bit_cyc) @(posedge clk);
        stop_q.push_back(tx_line);
        got_q.push_back(v);
      end
    end
  end
endmodule

// [tb/asci_top_tb.sv]
// bench for the serial interface: axi4-lite register traffic plus a remote node
// assumes one 100 MHz clock and the map of the design package
module asci_top_tb;
  import asci_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK = 0, RST = 1;
  logic [15:0] S_AXI_AWADDR = '0, S_AXI_ARADDR = '0;
  logic S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0;
  logic S_AXI_ARVALID = 0, S_AXI_RREADY = 0;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic [31:0] S_AXI_WDATA = '0, S_AXI_RDATA;
  logic [3:0] S_AXI_WSTRB = 4'hF;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, r;
  logic RXD, TXD, IRQ;
  logic [31:0] d;
  int bad_count = 0, checks = 0, n;
  // register row: address, written byte, read-back, response
  typedef struct {logic [15:0] a; logic [7:0] w; logic [7:0] e; logic [1:0] s;} asci_row_t;
  // receive row: char, stop level, glitch, send twice, status expected
  typedef struct {logic [7:0] v; logic st; logic gl; logic tw; logic [7:0] e;} asci_rxr_t;
  asci_row_t rows[5] = '{'{ASCI_ADDR_BAUD, 8'hFF, 8'hB7, ASCI_RESP_OK},
    '{ASCI_ADDR_BAUD, 8'h00, 8'h00, ASCI_RESP_OK}, '{ASCI_ADDR_CTL2, 8'h0C, 8'h0C, ASCI_RESP_OK},
    '{ASCI_ADDR_MASK, 8'h20, 8'h20, ASCI_RESP_OK}, '{16'h4000, 8'h5A, 8'h00, ASCI_RESP_SLVERR}};
  asci_rxr_t rxr[4] = '{'{8'h5A, 1, 0, 0, 8'hE0}, '{8'h11, 1, 0, 1, 8'hE8},
    '{8'h33, 0, 0, 0, 8'hE2}, '{8'h44, 1, 1, 0, 8'hE4}};
  logic [15:0] rst_a[5] = '{ASCI_ADDR_BAUD, ASCI_ADDR_CTL1, ASCI_ADDR_CTL2, ASCI_ADDR_MASK,
    ASCI_ADDR_STAT};
  logic [7:0] rst_e[5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hC0};
  logic [7:0] pre_code[4] = '{8'h00, 8'h10, 8'h20, 8'h31};
  int pre_bit[4] = '{16, 48, 64, 416};

  always #5 CLK = ~CLK;

  asci_top asci_top_inst (.CLK(CLK), .RST(RST), .S_AXI_AWADDR(S_AXI_AWADDR),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
    .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY), .RXD(RXD), .TXD(TXD), .IRQ(IRQ));
  asci_node asci_node_inst (.clk(CLK), .tx_line(TXD), .rx_line(RXD));

  // compare and count
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  // axi write; address and data offered together, each dropped once taken
  task automatic wr(input logic [15:0] a, input logic [7:0] v, output logic [1:0] rs);
    int k;
    k = 0;
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= {24'h000000, v};
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    do
    begin
      @(posedge CLK);
      k++;
      if (S_AXI_AWREADY === 1'b1) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY === 1'b1) S_AXI_WVALID <= 1'b0;
    end while (S_AXI_BVALID !== 1'b1 && k < 200);
    rs = S_AXI_BRESP;
    S_AXI_AWVALID <= 1'b0;
    S_AXI_WVALID <= 1'b0;
    S_AXI_BREADY <= 1'b0;
    if (k >= 200) bad_count++;
    @(posedge CLK);
  endtask

  // axi read; rready held until the answer
  task automatic rd(input logic [15:0] a, output logic [31:0] v, output logic [1:0] rs);
    int k;
    k = 0;
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do
    begin
      @(posedge CLK);
      k++;
      if (S_AXI_ARREADY === 1'b1) S_AXI_ARVALID <= 1'b0;
    end while (S_AXI_RVALID !== 1'b1 && k < 200);
    v = S_AXI_RDATA;
    rs = S_AXI_RRESP;
    S_AXI_ARVALID <= 1'b0;
    S_AXI_RREADY <= 1'b0;
    if (k >= 200) bad_count++;
    @(posedge CLK);
  endtask

  // bounded wait for the node to have decoded k characters
  task automatic wait_chars(input int k, input int lim);
    int c;
    c = 0;
    while (asci_node_inst.got_q.size() < k && c < lim)
    begin
      @(posedge CLK);
      c++;
    end
    if (c >= lim) bad_count++;
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // watchdog: the whole run needs about 8k clocks
  initial
  begin
    #600000;
    bad_count++;
    wrap_up();
  end

  // main sequence
  initial
  begin
    repeat (8) @(posedge CLK);
    RST <= 1'b0;
    chk("idle txd", 1, TXD);
    for (int i = 0; i < 5; i++)
    begin
      rd(rst_a[i], d, r);
      chk("reset value", rst_e[i], d);
    end
    $display("reset test done");
    for (int i = 0; i < 5; i++)
    begin
      wr(rows[i].a, rows[i].w, r);
      chk("write resp", rows[i].s, r);
      rd(rows[i].a, d, r);
      chk("read resp", rows[i].s, r);
      if (rows[i].s == ASCI_RESP_OK) chk("read back", rows[i].e, d);
    end
    $display("register rows done");
    // second character queued while the first shifts
    wr(ASCI_ADDR_DATA, 8'hA5, r);
    wr(ASCI_ADDR_DATA, 8'h3C, r);
    rd(ASCI_ADDR_STAT, d, r);
    chk("tx empty while queued", 0, d[ASCI_ST_TDRE]);
    wait_chars(2, 600);
    chk("tx char 1", 9'h0A5, asci_node_inst.got_q[0]);
    chk("tx char 2", 9'h03C, asci_node_inst.got_q[1]);
    chk("stop 1", 1, asci_node_inst.stop_q[0] & asci_node_inst.stop_q[1]);
    repeat (40) @(posedge CLK);
    rd(ASCI_ADDR_STAT, d, r);
    chk("tx done status", 8'hC0, d);
    $display("transmit test done");
    // receive cases: plain, overrun, framing, noise
    for (int i = 0; i < 4; i++)
    begin
      asci_node_inst.send({1'b0, rxr[i].v}, rxr[i].st, rxr[i].gl);
      if (rxr[i].tw) asci_node_inst.send({1'b0, rxr[i].v + 8'h11}, 1'b1, 1'b0);
      n = 0;
      while (IRQ !== 1'b1 && n < 100)
      begin
        @(posedge CLK);
        n++;
      end
      chk("irq rx full", 1, IRQ);
      rd(ASCI_ADDR_STAT, d, r);
      chk("rx status", rxr[i].e, d);
      rd(ASCI_ADDR_DATA, d, r);
      chk("rx data", rxr[i].v, d);
      repeat (2) @(posedge CLK);
      chk("irq cleared", 0, IRQ);
      rd(ASCI_ADDR_STAT, d, r);
      chk("flags cleared", 8'hC0, d);
    end
    $display("receive test done");
    // nine-bit character with the ninth bit set
    wr(ASCI_ADDR_CTL1, 8'h11, r);
    asci_node_inst.nbits = 9;
    wr(ASCI_ADDR_DATA, 8'h5A, r);
    wait_chars(3, 600);
    chk("nine bit char", 9'h15A, asci_node_inst.got_q[2]);
    asci_node_inst.nbits = 8;
    wr(ASCI_ADDR_CTL1, 8'h00, r);
    $display("word length test done");
    // bit time follows prescaler and rate select
    for (int i = 0; i < 4; i++)
    begin
      repeat (40) @(posedge CLK);
      wr(ASCI_ADDR_BAUD, pre_code[i], r);
      asci_node_inst.bit_cyc = pre_bit[i];
      wr(ASCI_ADDR_DATA, 8'h96, r);
      wait_chars(4 + i, 14 * pre_bit[i]);
      chk("rate char", 9'h096, asci_node_inst.got_q[3 + i]);
    end
    repeat (500) @(posedge CLK);
    wr(ASCI_ADDR_BAUD, 8'h00, r);
    asci_node_inst.bit_cyc = 16;
    $display("rate test done");
    // break holds the line low for whole frames
    wr(ASCI_ADDR_CTL2, 8'h0D, r);
    repeat (20) @(posedge CLK);
    n = 0;
    repeat (160)
    begin
      @(posedge CLK);
      if (TXD !== 1'b0) n++;
    end
    chk("break low", 0, n);
    wr(ASCI_ADDR_CTL2, 8'h0C, r);
    repeat (400) @(posedge CLK);
    chk("idle after break", 1, TXD);
    $display("break test done");
    // reset in mid-run brings the prescaler back to its fastest code
    wr(ASCI_ADDR_BAUD, 8'h31, r);
    RST <= 1'b1;
    repeat (8) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    rd(ASCI_ADDR_BAUD, d, r);
    chk("baud after reset", 0, d);
    $display("second reset test done");
    wrap_up();
  end
endmodule
